// >>> verilog/storage_controller_memory_arbiter.sv
// arbiter steering four storage bus controllers onto the cache memory cycle
// Behaviour
// - combined request latches four requests and raises address select
// - at T30 select output latch loads, data select driven to winner
// - at T120 priority history loads current selection; later choices use it
// - earliest arriving request is served first, like a lone request
// - request still pending: input latch reloads at T150 falling strobe
// - options clear: alternate A/B, C/D, and pair AB versus pair CD
// - history holds B-last, D-last and C-or-D-last flags
// - each option forces its history flag true while that option is set
// - all options set gives fixed order A, B, C, D
// - record outstanding reads, route data-ready only to its reader
// - two controller reads may be stacked on the memory bus
// - acknowledging a read at T30 sets that pending-read marker
// - no read in progress: pending read sets in-progress marker at once
// - second read waits, takes over when first data-ready ends
// - stacked read flag blocks third read, holds off timeout permit
// - during read-pause then write, other requests ignored until write
// - all eight option combinations, each fixing its left side
`timescale 1ns/1ns
`default_nettype none
module storage_controller_memory_arbiter
  import arb_pkg::*;
#(
  parameter int NUM = arb_pkg::NUM_CTRL
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire arb_pkg::ctrl_req_t  ctrlReq,
  input  wire arb_pkg::options_t   options,
  input  wire logic                memDataReady,
  output logic [NUM-1:0]           addressSelectStrobe,
  output logic [NUM-1:0]           dataSelectStrobe,
  output logic [NUM-1:0]           routedDataReady,
  output logic                     combinedControllerRequest,
  output logic                     requestAcknowledge,
  output logic                     readOutstandingIndication,
  output logic                     stackedReadFlag,
  output logic                     timeoutPermit,
  output arb_pkg::history_t        history
);
  import arb_pkg::*;

  // refuse any controller count the steering logic cannot serve
  if (NUM != NUM_CTRL) begin : gNumCheck
    $error("arbiter serves exactly four controllers");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  ctrl_req_t reqMeta;
  ctrl_req_t reqSync;
  logic      rdyMeta;
  logic      rdySync;
  logic      rdyLast;

  // two flops on the request and data-ready pin inputs; options is not synchronised
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqMeta <= '0;
      reqSync <= '0;
      rdyMeta <= 1'b0;
      rdySync <= 1'b0;
      rdyLast <= 1'b0;
    end else begin
      reqMeta <= ctrlReq;
      reqSync <= reqMeta;
      rdyMeta <= memDataReady;
      rdySync <= rdyMeta;
      rdyLast <= rdySync;
    end
  end

  // ------------------------------------------------------------
  // request blocking and combined request
  // ------------------------------------------------------------
  logic [NUM-1:0] pauseOwner;
  logic [NUM-1:0] liveReq;
  logic [NUM-1:0] pendRead;
  logic [NUM-1:0] inProg;
  logic [NUM-1:0] latchIn;

  // read-pause owner locks out the others until its write begins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pauseOwner <= '0;
    end else if ((pauseOwner & reqSync.writeStart) != '0) begin
      pauseOwner <= '0;
    end else if (pauseOwner == '0) begin
      pauseOwner <= reqSync.readPause & addressSelectStrobe;
    end
  end

  // third read blocked while two are stacked
  always_comb begin
    liveReq = reqSync.req;
    if (pauseOwner != '0) begin
      liveReq = reqSync.req & pauseOwner;
    end
    if (stackedReadFlag) begin
      liveReq = liveReq & ~reqSync.isRead;
    end
  end

  assign combinedControllerRequest = (liveReq != '0);

  // ------------------------------------------------------------
  // cache timing sequence
  // ------------------------------------------------------------
  seq_state_t     seqState;
  logic [3:0]     tState;
  logic [3:0]     stepCnt;
  logic           stepTick;

  assign stepTick = (stepCnt == STEP_CYC - 4'h1);

  // timing state counter, one state per step
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seqState <= SEQ_IDLE;
      tState   <= '0;
      stepCnt  <= '0;
    end else begin
      case (seqState)
        SEQ_IDLE: begin
          stepCnt <= '0;
          tState  <= '0;
          if (latchIn != '0) begin
            seqState <= SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          stepCnt <= stepTick ? 4'h0 : stepCnt + 4'h1;
          if (stepTick) begin
            tState <= tState + 4'h1;
            if (tState == SEQ_LAST) begin
              seqState <= SEQ_DONE;
            end
          end
        end
        SEQ_DONE: begin
          seqState <= SEQ_IDLE;
        end
        default: seqState <= SEQ_IDLE;
      endcase
    end
  end

  logic atT30;
  logic atT120;
  logic atT150;
  assign atT30  = (seqState == SEQ_RUN) && stepTick && (tState == T30_STATE);
  assign atT120 = (seqState == SEQ_RUN) && stepTick && (tState == T120_STATE);
  assign atT150 = (seqState == SEQ_RUN) && stepTick && (tState == T150_STATE);

  // ------------------------------------------------------------
  // input latch and priority choice
  // ------------------------------------------------------------
  logic [NUM-1:0] winner;
  logic [NUM-1:0] selOut;
  history_t       histReg;
  logic           upperWin;
  logic [NUM-1:0] eff;

  // first arrival latched alone; pending ones reloaded at T150
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      latchIn <= '0;
    end else if (seqState == SEQ_IDLE && latchIn == '0) begin
      latchIn <= liveReq;
    end else if (atT150) begin
      latchIn <= combinedControllerRequest ? liveReq : '0;
    end
  end

  // options force their flags true
  assign history.upperRecent     = histReg.upperRecent
                                   | options.upperPairFixed;
  assign history.lowerRecent     = histReg.lowerRecent
                                   | options.lowerPairFixed;
  assign history.pairOrderRecent = histReg.pairOrderRecent
                                   | options.pairOrderFixed;

  // alternations: flag true means left side goes next
  always_comb begin
    eff      = latchIn;
    winner   = '0;
    upperWin = (eff[CTRL_A] | eff[CTRL_B])
               & (history.pairOrderRecent | ~(eff[CTRL_C] | eff[CTRL_D]));
    if (upperWin) begin
      if (eff[CTRL_A] && (history.upperRecent || !eff[CTRL_B])) begin
        winner[CTRL_A] = 1'b1;
      end else begin
        winner[CTRL_B] = 1'b1;
      end
    end else if (eff[CTRL_C] | eff[CTRL_D]) begin
      if (eff[CTRL_C] && (history.lowerRecent || !eff[CTRL_D])) begin
        winner[CTRL_C] = 1'b1;
      end else begin
        winner[CTRL_D] = 1'b1; // falls out with all flags forced
      end
    end
  end

  assign addressSelectStrobe = (seqState == SEQ_RUN) ? winner : '0;

  // select output latch loaded at T30, cleared after sequence
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      selOut <= '0;
    end else if (atT30) begin
      selOut <= winner;
    end else if (seqState == SEQ_DONE) begin
      selOut <= '0;
    end
  end

  assign dataSelectStrobe   = selOut;
  assign requestAcknowledge = atT30;

  // history update from current selection at T120
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      histReg <= '0;
    end else if (atT120) begin
      if (selOut[CTRL_A]) histReg.upperRecent <= 1'b0;
      if (selOut[CTRL_B]) histReg.upperRecent <= 1'b1;
      if (selOut[CTRL_C]) histReg.lowerRecent <= 1'b0;
      if (selOut[CTRL_D]) histReg.lowerRecent <= 1'b1;
      if (selOut[CTRL_A] | selOut[CTRL_B]) histReg.pairOrderRecent <= 1'b0;
      if (selOut[CTRL_C] | selOut[CTRL_D]) histReg.pairOrderRecent <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // data-ready tracking of stacked reads
  // ------------------------------------------------------------
  logic rdyEnd;
  assign rdyEnd = rdyLast & ~rdySync;

  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : gRead
      // pending marker set on acknowledge, cleared when its read ends
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pendRead[g] <= 1'b0;
        end else if (atT30 && winner[g] && reqSync.isRead[g]) begin
          pendRead[g] <= 1'b1;
        end else if (rdyEnd && inProg[g]) begin
          pendRead[g] <= 1'b0;
        end
      end
      // in-progress marker; waiting reader takes over after data-ready
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          inProg[g] <= 1'b0;
        end else if (rdyEnd && inProg[g]) begin
          inProg[g] <= 1'b0;
        end else if (pendRead[g] && inProg == '0) begin
          inProg[g] <= 1'b1;
        end
      end
      assign routedDataReady[g] = rdySync & inProg[g];
    end
  endgenerate

  assign readOutstandingIndication = (inProg != '0);
  assign stackedReadFlag = ((pendRead & ~inProg) != '0);
  assign timeoutPermit   = ~stackedReadFlag;

endmodule : storage_controller_memory_arbiter
`default_nettype wire

// >>> pkg/arb_pkg.sv
// package of constants and carrier types for the controller memory arbiter
package arb_pkg;
  localparam int NUM_CTRL = 4;
  // cache timing states, counted in 30 ns time steps (STEP_CYC clock cycles each) of the cache sequence
  localparam int TIME_STEP_NS = 30;
  localparam int CLK_NS = 20;
  localparam logic [3:0] T30_STATE = 4'h1;
  localparam logic [3:0] T120_STATE = 4'h4;
  localparam logic [3:0] T150_STATE = 4'h5;
  localparam logic [3:0] SEQ_LAST = 4'h9;
  // step length in cycles, least time rounded up
  localparam int STEP_CYC_I = (TIME_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STEP_CYC = STEP_CYC_I[3:0];
  // controller indices
  localparam logic [1:0] CTRL_A = 2'h0;
  localparam logic [1:0] CTRL_B = 2'h1;
  localparam logic [1:0] CTRL_C = 2'h2;
  localparam logic [1:0] CTRL_D = 2'h3;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_RUN  = 2'b01,
    SEQ_DONE = 2'b11
  } seq_state_t;

  // priority history flags
  typedef struct packed {
    logic pairOrderRecent;   // lower_pair_recent_flag
    logic lowerRecent;       // fourth_unit_recent_flag
    logic upperRecent;       // second_unit_recent_flag
  } history_t;

  // priority options, one per alternation
  typedef struct packed {
    logic pairOrderFixed;
    logic lowerPairFixed;
    logic upperPairFixed;
  } options_t;

  // per-controller cycle request carrier
  typedef struct packed {
    logic [NUM_CTRL-1:0] req;
    logic [NUM_CTRL-1:0] isRead;
    logic [NUM_CTRL-1:0] readPause;
    logic [NUM_CTRL-1:0] writeStart;
  } ctrl_req_t;
endpackage : arb_pkg

// >>> bench/arb_checker_assertions.sv
// port checker of the controller memory arbiter
`timescale 1ns/1ns
`default_nettype none
module arb_checker
  import arb_pkg::*;
#(
  parameter int NUM = arb_pkg::NUM_CTRL
) (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire arb_pkg::ctrl_req_t ctrlReq,
  input wire arb_pkg::options_t  options,
  input wire logic               memDataReady,
  input wire logic [NUM-1:0]     addressSelectStrobe,
  input wire logic [NUM-1:0]     dataSelectStrobe,
  input wire logic [NUM-1:0]     routedDataReady,
  input wire logic               combinedControllerRequest,
  input wire logic               requestAcknowledge,
  input wire logic               readOutstandingIndication,
  input wire logic               stackedReadFlag,
  input wire logic               timeoutPermit,
  input wire arb_pkg::history_t  history
);
  import arb_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic rdAck;
  // acknowledge of a read cycle
  assign rdAck = requestAcknowledge && |(ctrlReq.isRead & addressSelectStrobe);
  sequence s_ack_soon;
    ##[1:8] requestAcknowledge;
  endsequence
  sequence s_stack_soon;
    ##[1:3] stackedReadFlag;
  endsequence
  property p_req_ack;
    $rose(|addressSelectStrobe) |-> s_ack_soon;
  endproperty
  a_req_ack: assert property (p_req_ack) else $error("no ack");
  property p_ds_win;
    requestAcknowledge |=> (dataSelectStrobe == $past(addressSelectStrobe))
      && $onehot(dataSelectStrobe);
  endproperty
  a_ds_win: assert property (p_ds_win) else $error("data select");
  property p_hist_forced;
    (3'(history) & 3'(options)) == 3'(options);
  endproperty
  a_hist_forced: assert property (p_hist_forced) else $error("forced");
  property p_hist_hold;
    !(|addressSelectStrobe) && $stable(options) |-> $stable(history);
  endproperty
  a_hist_hold: assert property (p_hist_hold) else $error("history");
  property p_no_third;
    stackedReadFlag |-> !rdAck;
  endproperty
  a_no_third: assert property (p_no_third) else $error("third");
  property p_first_read;
    rdAck && !readOutstandingIndication |-> ##[1:3] readOutstandingIndication;
  endproperty
  a_first_read: assert property (p_first_read) else $error("rip");
  property p_stack;
    rdAck && readOutstandingIndication |-> s_stack_soon;
  endproperty
  a_stack: assert property (p_stack) else $error("stack");
  property p_route;
    |routedDataReady |-> $onehot(routedDataReady) && readOutstandingIndication;
  endproperty
  a_route: assert property (p_route) else $error("route");
  property p_combined;
    combinedControllerRequest && !(|addressSelectStrobe)
      && !(|dataSelectStrobe) |-> ##[1:4] (|addressSelectStrobe);
  endproperty
  a_combined: assert property (p_combined) else $error("combined");
endmodule : arb_checker
bind storage_controller_memory_arbiter arb_checker #(.NUM(NUM)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .ctrlReq(ctrlReq), .options(options),
  .memDataReady(memDataReady), .addressSelectStrobe(addressSelectStrobe),
  .dataSelectStrobe(dataSelectStrobe), .routedDataReady(routedDataReady),
  .combinedControllerRequest(combinedControllerRequest),
  .requestAcknowledge(requestAcknowledge),
  .readOutstandingIndication(readOutstandingIndication),
  .stackedReadFlag(stackedReadFlag), .timeoutPermit(timeoutPermit),
  .history(history)
);
`default_nettype wire

// >>> bench/ctrl_mem_model.sv
// model of four storage bus controllers and the main memory
`timescale 1ns/1ns
`default_nettype none
module ctrl_mem_model
  import arb_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [3:0]         start,
  input  wire logic [3:0]         readSel,
  input  wire logic [7:0]         memWait,
  input  wire logic [3:0]         dataSel,
  input  wire logic [3:0]         addrSel,
  input  wire logic               ack,
  input  wire logic [3:0]         pauseSel,
  input  wire logic [3:0]         writeGo,
  output var  arb_pkg::ctrl_req_t req,
  output logic                    memReady
);
  import arb_pkg::*;
  int pend;
  int cnt;
  int lim;
  assign lim = memReady ? 3 : int'(memWait);
  // request held until data select, cycle kind while address select
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req <= '0;
    end else begin
      req.req <= (req.req | start) & ~dataSel;
      req.isRead <= (req.isRead | (start & readSel)) & (req.req | addrSel | start);
      // read-pause held until the write part begins
      req.readPause <= (req.readPause | (start & pauseSel)) & ~writeGo;
      req.writeStart <= writeGo;
    end
  end
  // memory answers reads in order, each data-ready held four cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend <= 0;
      cnt <= 0;
      memReady <= 1'b0;
    end else begin
      pend <= pend + int'(ack && |(addrSel & req.isRead))
        - int'(memReady && cnt == 3);
      cnt <= (pend == 0 || cnt == lim) ? 0 : cnt + 1;
      if (pend > 0 && cnt == lim) memReady <= !memReady;
    end
  end
endmodule : ctrl_mem_model
`default_nettype wire

// >>> bench/tb.sv
// testbench of the controller memory arbiter against a reference model
`timescale 1ns/1ns
`default_nettype none
module tb;
  import arb_pkg::*;
  logic       clk = 1'b0;
  logic       sys_rst;
  logic [3:0] start = 4'h0;
  logic [3:0] readSel = 4'h0;
  logic [7:0] memWait = 8'h28;
  logic [3:0] pauseSel = 4'h0, writeGo = 4'h0;
  options_t   options = '0;
  ctrl_req_t  ctrlReq;
  logic       memDataReady, combinedControllerRequest, requestAcknowledge;
  logic       readOutstandingIndication, stackedReadFlag, timeoutPermit;
  logic [3:0] addressSelectStrobe, dataSelectStrobe, routedDataReady;
  history_t   history;
  logic [3:0] grantQ[$], readyQ[$];
  logic [3:0] lastD = 4'h0, lastR = 4'h0;
  logic       sawStack = 1'b0;
  logic [31:0] seed = 32'hB59B6F20;
  int fails = 0, totalChecks = 0, cyc = 0, hb = 0, hd = 0, hcd = 0;
  initial begin
    forever #10 clk = ~clk;
  end
  storage_controller_memory_arbiter dut_u (.clk(clk), .sys_rst(sys_rst),
    .ctrlReq(ctrlReq), .options(options), .memDataReady(memDataReady),
    .addressSelectStrobe(addressSelectStrobe),
    .dataSelectStrobe(dataSelectStrobe), .routedDataReady(routedDataReady),
    .combinedControllerRequest(combinedControllerRequest),
    .requestAcknowledge(requestAcknowledge),
    .readOutstandingIndication(readOutstandingIndication),
    .stackedReadFlag(stackedReadFlag), .timeoutPermit(timeoutPermit),
    .history(history));
  ctrl_mem_model peer_u (.clk(clk), .sys_rst(sys_rst), .start(start),
    .readSel(readSel), .memWait(memWait), .dataSel(dataSelectStrobe),
    .pauseSel(pauseSel), .writeGo(writeGo),
    .addrSel(addressSelectStrobe), .ack(requestAcknowledge), .req(ctrlReq),
    .memReady(memDataReady));
  // log new grants and routed data-ready, cut a hang short
  // sampled on the falling edge, away from the launching edge
  always @(negedge clk) begin
    cyc <= cyc + 1;
    lastD <= dataSelectStrobe;
    lastR <= routedDataReady;
    if (|(dataSelectStrobe & ~lastD)) grantQ.push_back(dataSelectStrobe);
    if (|(routedDataReady & ~lastR)) readyQ.push_back(routedDataReady);
    if (stackedReadFlag === 1'b1 && timeoutPermit === 1'b0) sawStack <= 1'b1;
    if (cyc == 5000) begin
      fails++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // reference choice among pending units, history updated as served
  function automatic int pick(int p);
    int o, k;
    o = int'(3'(options));
    k = (p[1:0] != 0 && (p[3:2] == 0 || hcd | o[2])) ? 0 : 2;
    if (k == 0) k = (p[0] && (!p[1] || hb | o[0])) ? 0 : 1;
    else k = (p[2] && (!p[3] || hd | o[1])) ? 2 : 3;
    if (k < 2) hb = k;
    else hd = k - 2;
    hcd = int'(k >= 2);
    return k;
  endfunction : pick
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // m1 arrives first, m2 once m1 holds the address select
  task automatic round(input logic [3:0] m1, input logic [3:0] m2,
                       input logic [3:0] rd);
    int p, k, j, n;
    n = $countones(m1 | m2);
    readSel <= rd;
    start <= m1;
    @(posedge clk);
    start <= 4'h0;
    if (m2 != 0) begin
      for (k = 0; k < 200 && addressSelectStrobe === 4'h0; k++) @(posedge clk);
      start <= m2;
      @(posedge clk);
      start <= 4'h0;
    end
    for (k = 0; k < 400 && grantQ.size() < n; k++) @(posedge clk);
    for (k = 0; k < 100 && (addressSelectStrobe | dataSelectStrobe) !== 0; k++)
      @(posedge clk);
    p = int'(m1);
    for (k = 0; k < n; k++) begin
      if (k == 1) p = p | int'(m2);
      j = pick(p);
      p[j] = 1'b0;
      check("grant", 16'(1 << j), 16'(grantQ[k]));
    end
    check("history", 16'(3'(options) | 3'({hcd[0], hd[0], hb[0]})),
          16'(3'(history)));
    grantQ.delete();
  endtask : round
  task automatic stop_test();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // reset, every option setting, arrival order, stacked reads
  initial begin
    logic [31:0] m;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check("reset", 16'h0001, {addressSelectStrobe, dataSelectStrobe,
      routedDataReady, requestAcknowledge, readOutstandingIndication,
      stackedReadFlag, timeoutPermit});
    for (int o = 0; o < 16; o++) begin
      options <= options_t'(3'(o));
      m = rnd();
      @(posedge clk);
      round((m[3:0] == 4'h0) ? 4'hF : m[3:0], 4'h0, 4'h0);
    end
    round(4'h2, 4'h5, 4'h0);
    round(4'h9, 4'h0, 4'h9);
    for (int k = 0; k < 400 && readyQ.size() < 2; k++) @(posedge clk);
    check("routed first", 16'h1, 16'(readyQ[0]));
    check("routed second", 16'h8, 16'(readyQ[1]));
    check("stacked", 16'h1, 16'(sawStack));
    // B holds a read-pause lock, A waits until B's write begins
    grantQ.delete();
    readSel <= 4'h0;
    pauseSel <= 4'h2;
    start <= 4'h2;
    @(posedge clk);
    start <= 4'h1;
    pauseSel <= 4'h0;
    @(posedge clk);
    start <= 4'h0;
    repeat (120) @(posedge clk);
    check("locked grants", 16'h1, 16'(grantQ.size()));
    writeGo <= 4'h2;
    @(posedge clk);
    writeGo <= 4'h0;
    for (int k = 0; k < 200 && grantQ.size() < 2; k++) @(posedge clk);
    check("grant after write", 16'h1, 16'(grantQ[1]));
    stop_test();
  end
endmodule : tb
`default_nettype wire
